// [verilog/variable_monitor_dac_config.sv]
module variable_monitor_dac_config (
    // Clock and reset
    input  wire logic                                clk_sys_in,
    input  wire logic                                rst_n_in,
    // Register port from the serial interface engine
    input  wire logic [11:0]                         reg_addr_in,
    input  wire logic                                reg_wr_in,
    input  wire logic [31:0]                         reg_wdata_in,
    output logic      [31:0]                         reg_rdata_out,
    // Variable table fetch
    output logic      [monitor_dac_pkg::PTR_W-1:0]   var_addr_one_out,
    output logic      [monitor_dac_pkg::PTR_W-1:0]   var_addr_two_out,
    input  wire logic [monitor_dac_pkg::VAR_W-1:0]   var_data_one_in,
    input  wire logic [monitor_dac_pkg::VAR_W-1:0]   var_data_two_in,
    // Converter codes for the monitor pins
    output logic      [monitor_dac_pkg::CODE_W-1:0]  analog_monitor_out_one,
    output logic      [monitor_dac_pkg::CODE_W-1:0]  analog_monitor_out_two
);

    // ==================================================================
    // Scaling and voltage mapping
    // ==================================================================
    function automatic logic [monitor_dac_pkg::CODE_W-1:0] map_code(
        input logic [monitor_dac_pkg::VAR_W-1:0] raw,
        input monitor_dac_pkg::monitor_cfg_type  cfg
    );
        logic signed [31:0] prod;
        logic signed [31:0] scaled;
        logic signed [31:0] biased;
        prod   = 32'sh0;
        scaled = 32'sh0;
        biased = 32'sh0;
        if (cfg.gain != monitor_dac_pkg::GAIN_ENUM) begin
            // Linear gain in eighths, sign kept
            prod   = $signed({{16{raw[15]}}, raw}) * $signed({28'h0, cfg.gain});
            scaled = prod >>> monitor_dac_pkg::GAIN_FRAC;
        end else begin
            // Enumeration, 0..31, raised by the power-of-two shift
            scaled = $signed({27'h0, raw[monitor_dac_pkg::ENUM_W-1:0]}) <<< cfg.shift;
        end
        if (cfg.unipolar) begin
            // 0 pu at bottom of range, 1 pu at top
            if (scaled < monitor_dac_pkg::PU_ZERO) begin
                biased = monitor_dac_pkg::PU_ZERO;
            end else if (scaled > monitor_dac_pkg::PU_POS) begin
                biased = monitor_dac_pkg::PU_POS;
            end else begin
                biased = scaled;
            end
            map_code = biased[monitor_dac_pkg::UNI_DROP +: monitor_dac_pkg::CODE_W];
        end else begin
            // -1 pu at bottom, +1 pu at top, zero at mid-scale
            if (scaled < monitor_dac_pkg::PU_NEG) begin
                biased = monitor_dac_pkg::PU_NEG;
            end else if (scaled > monitor_dac_pkg::PU_POS) begin
                biased = monitor_dac_pkg::PU_POS;
            end else begin
                biased = scaled;
            end
            biased   = biased + monitor_dac_pkg::PU_BIAS;
            map_code = biased[monitor_dac_pkg::BIP_DROP +: monitor_dac_pkg::CODE_W];
        end
    endfunction

    // ==================================================================
    // Configuration registers
    // ==================================================================
    monitor_dac_pkg::monitor_cfg_type cfg_one_reg;
    monitor_dac_pkg::monitor_cfg_type cfg_one_next;
    monitor_dac_pkg::monitor_cfg_type cfg_two_reg;
    monitor_dac_pkg::monitor_cfg_type cfg_two_next;
    logic                             hit_one;
    logic                             hit_two;

    // Address decode and field unpacking on write
    always_comb begin
        hit_one      = (reg_addr_in == monitor_dac_pkg::CH1_CTRL_OFFSET);
        hit_two      = (reg_addr_in == monitor_dac_pkg::CH2_CTRL_OFFSET);
        cfg_one_next = cfg_one_reg;
        cfg_two_next = cfg_two_reg;
        if (reg_wr_in && hit_one) begin
            cfg_one_next.pointer  = {2'b00,
                reg_wdata_in[monitor_dac_pkg::CH1_PTR_LSB +: monitor_dac_pkg::CH1_PTR_W]};
            cfg_one_next.unipolar = reg_wdata_in[monitor_dac_pkg::CH1_POL_BIT];
            cfg_one_next.gain     =
                reg_wdata_in[monitor_dac_pkg::CH1_GAIN_LSB +: monitor_dac_pkg::FIELD_W];
            cfg_one_next.shift    =
                reg_wdata_in[monitor_dac_pkg::CH1_SHIFT_LSB +: monitor_dac_pkg::FIELD_W];
        end
        if (reg_wr_in && hit_two) begin
            cfg_two_next.pointer  =
                reg_wdata_in[monitor_dac_pkg::CH2_PTR_LSB +: monitor_dac_pkg::CH2_PTR_W];
            cfg_two_next.unipolar = reg_wdata_in[monitor_dac_pkg::CH2_POL_BIT];
            cfg_two_next.gain     =
                reg_wdata_in[monitor_dac_pkg::CH2_GAIN_LSB +: monitor_dac_pkg::FIELD_W];
            cfg_two_next.shift    =
                reg_wdata_in[monitor_dac_pkg::CH2_SHIFT_LSB +: monitor_dac_pkg::FIELD_W];
        end
    end

    // Register the configuration
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_one_reg <= monitor_dac_pkg::CFG_RESET;
            cfg_two_reg <= monitor_dac_pkg::CFG_RESET;
        end else begin
            cfg_one_reg <= cfg_one_next;
            cfg_two_reg <= cfg_two_next;
        end
    end

    // ==================================================================
    // Read-back path, combinational on the current address
    // ==================================================================
    always_comb begin
        reg_rdata_out = 32'h0;                           // Reserved and unmapped read zero
        if (hit_one) begin
            reg_rdata_out[monitor_dac_pkg::CH1_PTR_LSB +: monitor_dac_pkg::CH1_PTR_W] =
                cfg_one_reg.pointer[monitor_dac_pkg::CH1_PTR_W-1:0];
            reg_rdata_out[monitor_dac_pkg::CH1_POL_BIT] = cfg_one_reg.unipolar;
            reg_rdata_out[monitor_dac_pkg::CH1_GAIN_LSB +: monitor_dac_pkg::FIELD_W] =
                cfg_one_reg.gain;
            reg_rdata_out[monitor_dac_pkg::CH1_SHIFT_LSB +: monitor_dac_pkg::FIELD_W] =
                cfg_one_reg.shift;                       // Bits 31..21 stay zero
        end else if (hit_two) begin
            reg_rdata_out[monitor_dac_pkg::CH2_PTR_LSB +: monitor_dac_pkg::CH2_PTR_W] =
                cfg_two_reg.pointer;
            reg_rdata_out[monitor_dac_pkg::CH2_POL_BIT] = cfg_two_reg.unipolar;
            reg_rdata_out[monitor_dac_pkg::CH2_GAIN_LSB +: monitor_dac_pkg::FIELD_W] =
                cfg_two_reg.gain;
            reg_rdata_out[monitor_dac_pkg::CH2_SHIFT_LSB +: monitor_dac_pkg::FIELD_W] =
                cfg_two_reg.shift;
        end
    end

    // ==================================================================
    // Variable fetch and output codes
    // ==================================================================
    logic [monitor_dac_pkg::CODE_W-1:0] code_one_reg;
    logic [monitor_dac_pkg::CODE_W-1:0] code_one_next;
    logic [monitor_dac_pkg::CODE_W-1:0] code_two_reg;
    logic [monitor_dac_pkg::CODE_W-1:0] code_two_next;

    // Pointers drive the table address directly
    assign var_addr_one_out = cfg_one_reg.pointer;
    assign var_addr_two_out = cfg_two_reg.pointer;

    // Next converter codes from the fetched variables
    always_comb begin
        code_one_next = map_code(var_data_one_in, cfg_one_reg);
        code_two_next = map_code(var_data_two_in, cfg_two_reg);
    end

    // Register the codes so the pins see clean data
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            code_one_reg <= '0;
            code_two_reg <= '0;
        end else begin
            code_one_reg <= code_one_next;
            code_two_reg <= code_two_next;
        end
    end

    assign analog_monitor_out_one = code_one_reg;
    assign analog_monitor_out_two = code_two_reg;

endmodule // variable_monitor_dac_config

// [verilog/monitor_dac_pkg.sv]
package monitor_dac_pkg;

    // ==================================================================
    // Register map
    // ==================================================================
    localparam logic [11:0] CH1_CTRL_OFFSET = 12'h0f4;
    localparam logic [11:0] CH2_CTRL_OFFSET = 12'h0f6;

    // ==================================================================
    // Channel one field positions
    // ==================================================================
    localparam int CH1_PTR_LSB   = 0;
    localparam int CH1_PTR_W     = 12;
    localparam int CH1_POL_BIT   = 12;
    localparam int CH1_GAIN_LSB  = 13;
    localparam int CH1_SHIFT_LSB = 17;

    // ==================================================================
    // Channel two field positions
    // ==================================================================
    localparam int CH2_PTR_LSB   = 0;
    localparam int CH2_PTR_W     = 14;
    localparam int CH2_POL_BIT   = 14;
    localparam int CH2_GAIN_LSB  = 15;
    localparam int CH2_SHIFT_LSB = 19;

    // ==================================================================
    // Common widths and reset values
    // ==================================================================
    localparam int          PTR_W       = 14;
    localparam int          FIELD_W     = 4;
    localparam logic [3:0]  GAIN_RESET  = 4'h8;
    localparam logic [3:0]  SHIFT_RESET = 4'h8;
    localparam logic [3:0]  GAIN_ENUM   = 4'h0;
    localparam int          GAIN_FRAC   = 3;
    localparam int          ENUM_W      = 5;
    localparam int          VAR_W       = 16;
    localparam int          CODE_W      = 12;

    // ==================================================================
    // Per-unit scaling: 1 pu is 2^15 in the variable format
    // ==================================================================
    localparam logic signed [31:0] PU_POS   = 32'sh00007fff;
    localparam logic signed [31:0] PU_NEG   = -32'sh00008000;
    localparam logic signed [31:0] PU_ZERO  = 32'sh00000000;
    localparam logic signed [31:0] PU_BIAS  = 32'sh00008000;
    localparam int                 UNI_DROP = 3;
    localparam int                 BIP_DROP = 4;

    // ==================================================================
    // Channel configuration carrier
    // ==================================================================
    typedef struct packed {
        logic [3:0]       shift;
        logic [3:0]       gain;
        logic             unipolar;
        logic [PTR_W-1:0] pointer;
    } monitor_cfg_type;

    localparam monitor_cfg_type CFG_RESET = '{
        shift:    SHIFT_RESET,
        gain:     GAIN_RESET,
        unipolar: 1'b0,
        pointer:  '0
    };

endpackage

// [bench/monitor_var_table.sv]
// ==========================================
// Variable table seen by one monitor channel
// ==========================================
module monitor_var_table (
    // Fetch port
    input  wire logic [13:0] addr_in,
    output logic      [15:0] data_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Answers at once; low pointer bits pick a signed value, pointer 0 gives zero
    assign data_out = {addr_in[11:0], 4'h0};
endmodule // monitor_var_table

// [bench/variable_monitor_dac_config_properties.sv]
// ==========================================
// Port checker for the monitor configuration
// ==========================================
module monitor_dac_checker (
    // Clock and reset
    input wire logic        clk_sys_in,
    input wire logic        rst_n_in,
    // Register port
    input wire logic [11:0] reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic [31:0] reg_rdata_out,
    // Fetch and output path
    input wire logic [13:0] var_addr_one_out,
    input wire logic [13:0] var_addr_two_out,
    input wire logic [15:0] var_data_one_in,
    input wire logic [11:0] analog_monitor_out_one
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // Register readback and pointers
    AST_CH1_RSV_ZERO: assert property (reg_addr_in == 12'h0f4 |-> reg_rdata_out[31:21] == 11'h000)
        else $error("channel one reserved bits read nonzero");
    AST_CH2_RSV_ZERO: assert property (reg_addr_in == 12'h0f6 |-> reg_rdata_out[31:23] == 9'h000)
        else $error("channel two reserved bits read nonzero");
    AST_CH1_READBACK: assert property ((reg_wr_in && reg_addr_in == 12'h0f4) ##1 reg_addr_in == 12'h0f4
        |-> reg_rdata_out == ($past(reg_wdata_in) & 32'h001fffff)) else $error("channel one readback");
    AST_PTR1_WRITE: assert property (reg_wr_in && reg_addr_in == 12'h0f4
        |=> var_addr_one_out == {2'b00, $past(reg_wdata_in[11:0])}) else $error("pointer one");
    AST_PTR1_HIGH_ZERO: assert property (var_addr_one_out[13:12] == 2'b00)
        else $error("pointer one upper bits");
    AST_PTR2_WRITE: assert property (reg_wr_in && reg_addr_in == 12'h0f6
        |=> var_addr_two_out == $past(reg_wdata_in[13:0])) else $error("pointer two");
    // Output mapping end points
    AST_BIPOLAR_CENTRE: assert property ((reg_addr_in == 12'h0f4 && !reg_rdata_out[12]
        && reg_rdata_out[16:13] != 4'h0 && var_data_one_in == 16'h0000)
        |=> analog_monitor_out_one == 12'h800) else $error("bipolar zero not centred");
    AST_UNIPOLAR_FLOOR: assert property ((reg_addr_in == 12'h0f4 && reg_rdata_out[12]
        && reg_rdata_out[16:13] != 4'h0 && var_data_one_in[15])
        |=> analog_monitor_out_one == 12'h000) else $error("unipolar negative not floored");
    // Main scenarios
    COV_CH2_WRITE: cover property (reg_wr_in && reg_addr_in == 12'h0f6);
    COV_ENUM_OUT: cover property (reg_addr_in == 12'h0f4 && reg_rdata_out[16:13] == 4'h0);
    COV_UNIPOLAR: cover property (reg_addr_in == 12'h0f4 && reg_rdata_out[12]);
endmodule // monitor_dac_checker
bind variable_monitor_dac_config monitor_dac_checker u_checker (.clk_sys_in, .rst_n_in,
    .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out, .var_addr_one_out,
    .var_addr_two_out, .var_data_one_in, .analog_monitor_out_one);

// [bench/test_variable_monitor_dac_config.sv]
// ==========================================
// Self-checking bench for the monitor configuration
// ==========================================
module test_variable_monitor_dac_config;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [11:0] reg_addr_in = 12'h000;
    logic        reg_wr_in = 1'b0;
    logic [31:0] reg_wdata_in = 32'h00000000;
    logic [31:0] reg_rdata_out;
    logic [13:0] var_addr_one_out, var_addr_two_out;
    logic [15:0] var_data_one_in, var_data_two_in;
    logic [11:0] analog_monitor_out_one, analog_monitor_out_two;
    int          error_cnt = 0;
    int          compares = 0;
    // Clock at 40 MHz
    always #12.5 clk_sys_in = ~clk_sys_in;
    // Design and its two variable tables
    variable_monitor_dac_config DUT (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wr_in,
        .reg_wdata_in, .reg_rdata_out, .var_addr_one_out, .var_addr_two_out, .var_data_one_in,
        .var_data_two_in, .analog_monitor_out_one, .analog_monitor_out_two);
    monitor_var_table table_one (.addr_in(var_addr_one_out), .data_out(var_data_one_in));
    monitor_var_table table_two (.addr_in(var_addr_two_out), .data_out(var_data_two_in));
    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in  <= a;
        reg_wr_in    <= 1'b1;
        reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        #1;
        chk(what, exp, reg_rdata_out);
    endtask
    // Expected converter code from variable and settings
    function automatic logic [11:0] exp_code(logic [15:0] v, logic [3:0] g, logic [3:0] sh, logic p);
        int s;
        if (g != 4'h0) s = ($signed(v) * int'(g)) >>> 3;
        else s = int'(v[4:0]) << sh;
        if (s > 32767) s = 32767;
        if (p) return (s < 0) ? 12'h000 : s[14:3];
        if (s < -32768) s = -32768;
        s = s + 32768;
        return s[15:4];
    endfunction
    // ==========================================
    // Scenarios
    // ==========================================
    task automatic test_reset();
        rd(12'h0f4, 32'h00110000, "ch1 reset");
        rd(12'h0f6, 32'h00440000, "ch2 reset");
        chk("ptr1 reset", 32'h0, {18'h0, var_addr_one_out});
    endtask
    task automatic test_fields();
        wr(12'h0f4, 32'hffe02123); // Reserved ones on purpose
        rd(12'h0f4, 32'h00002123, "ch1 rsv");
        chk("ptr1", 32'h123, {18'h0, var_addr_one_out});
        wr(12'h0f6, 32'hff92fabc);
        rd(12'h0f6, 32'h0012fabc, "ch2 fields");
        chk("ptr2", 32'h3abc, {18'h0, var_addr_two_out});
        chk("code2", 32'h0, {20'h0, analog_monitor_out_two});
        wr(12'h0f5, 32'h00000fff);
        rd(12'h0f5, 32'h0, "unmapped");
        rd(12'h0f4, 32'h00002123, "ch1 kept");
    endtask
    task automatic test_mapping();
        logic [11:0] ptrs[4] = '{12'h800, 12'h7ff, 12'h000, 12'h001};
        logic [3:0]  shs[3] = '{4'h0, 4'h3, 4'hf};
        for (int g = 0; g < 16; g++) begin
            for (int s = 0; s < 3; s++) begin
                for (int p = 0; p < 2; p++) begin
                    for (int i = 0; i < 4; i++) begin
                        wr(12'h0f4, {11'h0, shs[s], g[3:0], p[0], ptrs[i]});
                        @(posedge clk_sys_in);
                        #1;
                        chk("code1", {20'h0, exp_code({ptrs[i], 4'h0}, g[3:0], shs[s], p[0])},
                            {20'h0, analog_monitor_out_one});
                    end
                end
            end
        end
    endtask
    task automatic summarize();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        test_reset();
        test_fields();
        test_mapping();
        summarize();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #200us;
        error_cnt++;
        summarize();
    end
endmodule // test_variable_monitor_dac_config
